// >>> core/rac_alarm_ctrl.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rac_params.svh"

module rac_alarm_ctrl (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_manual_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Calendar and divider events
    input wire rac_pkg::rac_cal_s i_cal,
    input wire logic i_low_alarm_match,
    input wire logic i_low_alarm_enabled,
    input wire logic i_second_carry,
    input wire logic i_sub_second_read_carry,
    input wire logic [6:0] i_period_ticks,
    // Controls and requests
    output rac_pkg::rac_run_s o_run,
    output rac_pkg::rac_irq_s o_irq
);

    // State loaded by power-on reset
    typedef struct packed {
        logic carry_flag;
        logic carry_irq_enable;
        logic alarm_irq_enable;
        logic alarm_flag;
        logic periodic_flag;
        logic [2:0] period_select;
        logic oscillator_enable;
        logic count_start;
        logic year_alarm_enable;
        logic hour_en;
        logic weekday_en;
        logic day_en;
        logic month_en;
        logic divider_reset;
        logic adjust;
        logic [31:0] rdata;
        logic slverr;
    } rac_state_s;

    // Alarm values kept through every reset
    typedef struct packed {
        logic [`RAC_HOUR_W-1:0] hour;
        logic [`RAC_WEEKDAY_W-1:0] weekday;
        logic [`RAC_DAY_W-1:0] day;
        logic [`RAC_MONTH_W-1:0] month;
        logic [`RAC_YEAR_W-1:0] year;
    } rac_keep_s;

    rac_state_s state_q;
    rac_state_s state_d;
    rac_keep_s keep_q;
    rac_keep_s keep_d;
    logic [31:0] rd_mux;
    logic addr_hit;
    logic wr_acc;
    logic wr_b0;
    logic match_all;
    logic any_enabled;
    logic period_tick;
    logic [7:0] wb;
    logic hour_agree;
    logic weekday_agree;
    logic day_agree;
    logic month_agree;
    logic year_agree;

    // Access phase completes at once
    assign o_pready = 1'b1;
    assign wr_acc = i_psel & i_penable & i_pwrite;
    assign wr_b0 = wr_acc & i_pstrb[0];
    assign wb = i_pwdata[7:0];

    // Hour field against its counter
    rac_field_match #(
        .W(`RAC_HOUR_W)
    ) hour_field_inst (
        .i_en(state_q.hour_en),
        .i_alarm(keep_q.hour),
        .i_count(i_cal.hour[`RAC_HOUR_W-1:0]),
        .o_agree(hour_agree)
    );

    // Weekday field against its counter
    rac_field_match #(
        .W(`RAC_WEEKDAY_W)
    ) weekday_field_inst (
        .i_en(state_q.weekday_en),
        .i_alarm(keep_q.weekday),
        .i_count(i_cal.weekday[`RAC_WEEKDAY_W-1:0]),
        .o_agree(weekday_agree)
    );

    // Day field against its counter
    rac_field_match #(
        .W(`RAC_DAY_W)
    ) day_field_inst (
        .i_en(state_q.day_en),
        .i_alarm(keep_q.day),
        .i_count(i_cal.day[`RAC_DAY_W-1:0]),
        .o_agree(day_agree)
    );

    // Month field against its counter
    rac_field_match #(
        .W(`RAC_MONTH_W)
    ) month_field_inst (
        .i_en(state_q.month_en),
        .i_alarm(keep_q.month),
        .i_count(i_cal.month[`RAC_MONTH_W-1:0]),
        .o_agree(month_agree)
    );

    // Year field against its counter
    rac_field_match #(
        .W(`RAC_YEAR_W)
    ) year_field_inst (
        .i_en(state_q.year_alarm_enable),
        .i_alarm(keep_q.year),
        .i_count(i_cal.year),
        .o_agree(year_agree)
    );

    // All enabled fields and the low alarm agree at once, live every cycle
    always_comb begin
        match_all = i_low_alarm_match & hour_agree & weekday_agree & day_agree
            & month_agree & year_agree;
        any_enabled = i_low_alarm_enabled | state_q.hour_en | state_q.weekday_en
            | state_q.day_en | state_q.month_en | state_q.year_alarm_enable;
    end

    // Tick of the selected period
    always_comb begin
        period_tick = 1'b0;
        if (state_q.period_select != `RAC_PSEL_OFF) begin
            period_tick = i_period_ticks[state_q.period_select - 3'h1];
        end
    end

    // Read data and address decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        addr_hit = 1'b1;
        unique case (i_paddr)
            // Hour alarm: enable and value
            `RAC_OFF_HOUR_ALARM: begin
                rd_mux[`RAC_ALARM_EN_BIT] = state_q.hour_en;
                rd_mux[`RAC_HOUR_W-1:0] = keep_q.hour;
            end
            // Weekday alarm: enable and value
            `RAC_OFF_WEEKDAY_ALARM: begin
                rd_mux[`RAC_ALARM_EN_BIT] = state_q.weekday_en;
                rd_mux[`RAC_WEEKDAY_W-1:0] = keep_q.weekday;
            end
            // Day alarm: enable and value
            `RAC_OFF_DAY_ALARM: begin
                rd_mux[`RAC_ALARM_EN_BIT] = state_q.day_en;
                rd_mux[`RAC_DAY_W-1:0] = keep_q.day;
            end
            // Month alarm: enable and value
            `RAC_OFF_MONTH_ALARM: begin
                rd_mux[`RAC_ALARM_EN_BIT] = state_q.month_en;
                rd_mux[`RAC_MONTH_W-1:0] = keep_q.month;
            end
            // Flags and their interrupt enables
            `RAC_OFF_FLAG_CTRL: begin
                rd_mux[`RAC_CF_BIT] = state_q.carry_flag;
                rd_mux[`RAC_CIE_BIT] = state_q.carry_irq_enable;
                rd_mux[`RAC_AIE_BIT] = state_q.alarm_irq_enable;
                rd_mux[`RAC_AF_BIT] = state_q.alarm_flag;
            end
            // Period and run bits; pulse bits read zero
            `RAC_OFF_PERIOD_CTRL: begin
                rd_mux[`RAC_PEF_BIT] = state_q.periodic_flag;
                rd_mux[`RAC_PSEL_LSB+:3] = state_q.period_select;
                rd_mux[`RAC_OSC_BIT] = state_q.oscillator_enable;
                rd_mux[`RAC_START_BIT] = state_q.count_start;
            end
            // Year alarm enable only
            `RAC_OFF_YEAR_CTRL: begin
                rd_mux[`RAC_YEAR_ALARM_ENABLE_BIT] = state_q.year_alarm_enable;
            end
            // Year alarm value
            `RAC_OFF_YEAR_ALARM: begin
                rd_mux[`RAC_YEAR_W-1:0] = keep_q.year;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Next state of all registers
    always_comb begin
        state_d = state_q;
        keep_d = keep_q;
        // Write-only pulse bits last one cycle
        state_d.divider_reset = 1'b0;
        state_d.adjust = 1'b0;
        // Capture read data in the setup phase
        if (i_psel & ~i_penable) begin
            state_d.rdata = addr_hit ? rd_mux : 32'h0000_0000;
            state_d.slverr = ~addr_hit;
        end
        // Register writes at access completion
        if (wr_b0 & addr_hit) begin
            unique case (i_paddr)
                // Hour alarm enable and value
                `RAC_OFF_HOUR_ALARM: begin
                    state_d.hour_en = wb[`RAC_ALARM_EN_BIT];
                    keep_d.hour = wb[`RAC_HOUR_W-1:0];
                end
                // Weekday alarm enable and value
                `RAC_OFF_WEEKDAY_ALARM: begin
                    state_d.weekday_en = wb[`RAC_ALARM_EN_BIT];
                    keep_d.weekday = wb[`RAC_WEEKDAY_W-1:0];
                end
                // Day alarm enable and value
                `RAC_OFF_DAY_ALARM: begin
                    state_d.day_en = wb[`RAC_ALARM_EN_BIT];
                    keep_d.day = wb[`RAC_DAY_W-1:0];
                end
                // Month alarm enable and value
                `RAC_OFF_MONTH_ALARM: begin
                    state_d.month_en = wb[`RAC_ALARM_EN_BIT];
                    keep_d.month = wb[`RAC_MONTH_W-1:0];
                end
                `RAC_OFF_FLAG_CTRL: begin
                    // Zero clears a flag, one keeps it; reserved bits dropped
                    state_d.carry_flag = state_q.carry_flag & wb[`RAC_CF_BIT];
                    state_d.alarm_flag = state_q.alarm_flag & wb[`RAC_AF_BIT];
                    state_d.carry_irq_enable = wb[`RAC_CIE_BIT];
                    state_d.alarm_irq_enable = wb[`RAC_AIE_BIT];
                end
                // Period flag clear, select, run bits and pulses
                `RAC_OFF_PERIOD_CTRL: begin
                    state_d.periodic_flag = state_q.periodic_flag & wb[`RAC_PEF_BIT];
                    state_d.period_select = wb[`RAC_PSEL_LSB+:3];
                    state_d.oscillator_enable = wb[`RAC_OSC_BIT];
                    state_d.count_start = wb[`RAC_START_BIT];
                    state_d.adjust = wb[`RAC_ADJ_BIT];
                    state_d.divider_reset = wb[`RAC_DIVRST_BIT] | wb[`RAC_ADJ_BIT];
                end
                // Year alarm enable; low bits dropped
                `RAC_OFF_YEAR_CTRL: begin
                    state_d.year_alarm_enable = wb[`RAC_YEAR_ALARM_ENABLE_BIT];
                end
                // Lower byte of the year alarm
                `RAC_OFF_YEAR_ALARM: begin
                    keep_d.year[7:0] = wb;
                end
                default: begin
                end
            endcase
        end
        // Upper byte of the year alarm
        if (wr_acc & i_pstrb[1] & (i_paddr == `RAC_OFF_YEAR_ALARM)) begin
            keep_d.year[15:8] = i_pwdata[15:8];
        end
        // Manual reset spares oscillator and start
        if (i_manual_rst) begin
            state_d.carry_irq_enable = 1'b0;
            state_d.alarm_irq_enable = 1'b0;
            // Periodic state cleared as well
            state_d.periodic_flag = 1'b0;
            state_d.period_select = `RAC_PSEL_OFF;
            state_d.adjust = 1'b0;
            state_d.divider_reset = 1'b0;
        end
        // Hardware sets win over clears: carry events
        if (i_second_carry | i_sub_second_read_carry) begin
            state_d.carry_flag = 1'b1;
        end
        // Alarm flag set while a match persists, held after it ends
        if (match_all & any_enabled) begin
            state_d.alarm_flag = 1'b1;
        end
        // Selected period elapsed
        if (period_tick) begin
            state_d.periodic_flag = 1'b1;
        end
    end

    // Resettable state, power-on reset
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Flags and enables clear; run bits taken from the reset word
            state_q <= '0;
            state_q.oscillator_enable <= 1'(`RAC_PERIOD_CTRL_RST >> `RAC_OSC_BIT);
            state_q.count_start <= 1'(`RAC_PERIOD_CTRL_RST >> `RAC_START_BIT);
        end else begin
            state_q <= state_d;
        end
    end

    // Alarm values, no reset at all
    always_ff @(posedge i_core_clk) begin
        keep_q <= keep_d;
    end

    // Bus answer
    assign o_prdata = state_q.rdata;
    assign o_pslverr = state_q.slverr & i_psel & i_penable;

    // Run controls
    assign o_run.oscillator_enable = state_q.oscillator_enable;
    assign o_run.count_start = state_q.count_start;
    assign o_run.divider_reset = state_q.divider_reset;
    assign o_run.thirty_second_adjust = state_q.adjust;

    // Interrupt requests
    assign o_irq.alarm = state_q.alarm_flag & state_q.alarm_irq_enable;
    assign o_irq.carry = state_q.carry_flag & state_q.carry_irq_enable;
    assign o_irq.periodic = state_q.periodic_flag
        & (state_q.period_select != `RAC_PSEL_OFF);

endmodule // rac_alarm_ctrl

// One alarm field against its counter
module rac_field_match #(
    parameter int W = 8
) (
    // Enable and values
    input wire logic i_en,
    input wire logic [W-1:0] i_alarm,
    input wire logic [W-1:0] i_count,
    // Agreement
    output logic o_agree
);

    // A disabled field never blocks the all-match
    assign o_agree = ~i_en | (i_alarm == i_count);

endmodule // rac_field_match

`default_nettype wire

// >>> core/rac_params.svh
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH

// Register byte offsets on the APB bus
`define RAC_OFF_HOUR_ALARM 12'h000
`define RAC_OFF_WEEKDAY_ALARM 12'h004
`define RAC_OFF_DAY_ALARM 12'h008
`define RAC_OFF_MONTH_ALARM 12'h00C
`define RAC_OFF_FLAG_CTRL 12'h010
`define RAC_OFF_PERIOD_CTRL 12'h014
`define RAC_OFF_YEAR_CTRL 12'h018
`define RAC_OFF_YEAR_ALARM 12'h01C

// Alarm register fields
`define RAC_ALARM_EN_BIT 7
`define RAC_HOUR_W 6
`define RAC_WEEKDAY_W 3
`define RAC_DAY_W 6
`define RAC_MONTH_W 5
`define RAC_YEAR_W 16

// Flag and interrupt control fields
`define RAC_CF_BIT 7
`define RAC_CIE_BIT 4
`define RAC_AIE_BIT 3
`define RAC_AF_BIT 0

// Period and run control fields
`define RAC_PEF_BIT 7
`define RAC_PSEL_LSB 4
`define RAC_OSC_BIT 3
`define RAC_ADJ_BIT 2
`define RAC_DIVRST_BIT 1
`define RAC_START_BIT 0
`define RAC_PERIOD_CTRL_RST 8'h09
`define RAC_PSEL_OFF 3'h0

// Year alarm control fields
`define RAC_YEAR_ALARM_ENABLE_BIT 7

`endif

// >>> core/rac_pkg.sv
package rac_pkg;

    // Running calendar counters, BCD
    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] weekday;
        logic [7:0] day;
        logic [7:0] month;
        logic [15:0] year;
    } rac_cal_s;

    // Interrupt request lines
    typedef struct packed {
        logic alarm;
        logic periodic;
        logic carry;
    } rac_irq_s;

    // Run controls towards the counter chain
    typedef struct packed {
        logic oscillator_enable;
        logic count_start;
        logic divider_reset;
        logic thirty_second_adjust;
    } rac_run_s;

endpackage

// >>> testbench/rac_alarm_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rac_alarm_ctrl_sva (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_manual_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    // Controls and requests
    input wire rac_pkg::rac_run_s o_run,
    input wire rac_pkg::rac_irq_s o_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Access phase decode
    logic acc, wr_run, wr_flag;
    assign acc = i_psel && i_penable;
    assign wr_run = acc && i_pwrite && i_pstrb[0] && i_paddr == 12'h014 && !i_manual_rst;
    assign wr_flag = acc && i_pwrite && i_pstrb[0] && i_paddr == 12'h010;
    // Run control request steps
    sequence s_divrst_req; wr_run && i_pwdata[1]; endsequence
    sequence s_adj_req; wr_run && i_pwdata[2]; endsequence
    sequence s_adj_pulse; o_run.thirty_second_adjust && o_run.divider_reset; endsequence
    property p_divrst; s_divrst_req |-> ##[1:2] o_run.divider_reset; endproperty
    a_divrst: assert property (p_divrst) else $error("no divider reset pulse");
    property p_adj; s_adj_req |-> ##[1:2] s_adj_pulse; endproperty
    a_adj: assert property (p_adj) else $error("no adjust pulse");
    property p_manual_irq; i_manual_rst |=> !o_irq.alarm && !o_irq.carry && !o_irq.periodic; endproperty
    a_manual_irq: assert property (p_manual_irq) else $error("irq after manual reset");
    property p_manual_keep;
        i_manual_rst && !i_psel |=> $stable(o_run.oscillator_enable) && $stable(o_run.count_start);
    endproperty
    a_manual_keep: assert property (p_manual_keep) else $error("run bits lost");
    property p_carry_keep; o_irq.carry && !i_manual_rst && !wr_flag |=> o_irq.carry; endproperty
    a_carry_keep: assert property (p_carry_keep) else $error("carry irq dropped");
    property p_rd_flag;
        acc && !i_pwrite && i_paddr == 12'h010 |-> o_prdata[6:5] == 2'h0 && o_prdata[2:1] == 2'h0;
    endproperty
    a_rd_flag: assert property (p_rd_flag) else $error("reserved flag bits set");
    property p_rd_year; acc && !i_pwrite && i_paddr == 12'h018 |-> o_prdata[6:0] == 7'h00; endproperty
    a_rd_year: assert property (p_rd_year) else $error("year control low bits set");
    property p_rst_run; $rose(i_rst_b) |-> o_run.oscillator_enable && o_run.count_start; endproperty
    a_rst_run: assert property (p_rst_run) else $error("run bits not set by reset");
endmodule // rac_alarm_ctrl_sva
bind rac_alarm_ctrl rac_alarm_ctrl_sva rac_alarm_ctrl_sva_inst (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_manual_rst(i_manual_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_run(o_run), .o_irq(o_irq));
`default_nettype wire

// >>> testbench/rac_alarm_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rac_alarm_ctrl_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, mrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic sc = 1'b0, rc = 1'b0, lm = 1'b1, le = 1'b0, pready, perr, re;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [6:0] tk = 7'h00;
    rac_pkg::rac_cal_s cal = '0;
    rac_pkg::rac_run_s run;
    rac_pkg::rac_irq_s irq;
    int errors = 0, checked = 0, n_div = 0, n_adj = 0;
    // Clock
    always #2 clk = ~clk;
    rac_alarm_ctrl rac_alarm_ctrl_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_manual_rst(mrst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .i_pstrb(4'hF), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr), .i_cal(cal),
        .i_low_alarm_match(lm), .i_low_alarm_enabled(le), .i_second_carry(sc),
        .i_sub_second_read_carry(rc), .i_period_ticks(tk), .o_run(run), .o_irq(irq));
    // Count run control pulses
    always @(posedge clk) begin
        n_div += (run.divider_reset === 1'b1);
        n_adj += (run.thirty_second_adjust === 1'b1);
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prd;
        re = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // One-cycle side pulse: 0 second carry, 1 read carry, 2 manual reset
    task automatic pulse(input int k);
        @(posedge clk);
        sc <= (k == 0);
        rc <= (k == 1);
        mrst <= (k == 2);
        @(posedge clk);
        sc <= 1'b0;
        rc <= 1'b0;
        mrst <= 1'b0;
    endtask
    task automatic t_reset;
        rchk(12'h010, 32'h0);
        rchk(12'h014, 32'h9);
        rchk(12'h018, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("alarm enable", rd[7], 1'b0);
        end
        $display("reset test done");
    endtask
    task automatic t_regs;
        logic [31:0] w [4] = '{32'hE3, 32'hFE, 32'hF1, 32'hF2};
        logic [31:0] m [4] = '{32'hA3, 32'h86, 32'hB1, 32'h92};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'(4 * i), w[i]);
            rchk(12'(4 * i), m[i]);
            apb(1'b1, 12'(4 * i), 32'h0);
        end
        apb(1'b1, 12'h01C, 32'h2024);
        rchk(12'h01C, 32'h2024);
        $display("alarm register test done");
    endtask
    task automatic t_alarm;
        cal <= '{hour: 8'h12, weekday: 8'h03, day: 8'h15, month: 8'h06, year: 16'h2024};
        apb(1'b1, 12'h000, 32'h92);
        apb(1'b1, 12'h010, 32'h08);
        settle(1);
        check("alarm irq", irq.alarm, 1'b1);
        rchk(12'h010, 32'h09);
        apb(1'b1, 12'h010, 32'h08);
        rchk(12'h010, 32'h09);
        cal.hour <= 8'h13;
        apb(1'b1, 12'h010, 32'h09);
        rchk(12'h010, 32'h09);
        apb(1'b1, 12'h010, 32'h08);
        rchk(12'h010, 32'h08);
        cal.hour <= 8'h12;
        lm <= 1'b0;
        apb(1'b1, 12'h018, 32'h80);
        apb(1'b1, 12'h01C, 32'h2025);
        lm <= 1'b1;
        settle(2);
        check("alarm irq", irq.alarm, 1'b0);
        apb(1'b1, 12'h01C, 32'h2024);
        settle(2);
        check("alarm irq", irq.alarm, 1'b1);
        apb(1'b1, 12'h018, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        le <= 1'b1;
        settle(1);
        rchk(12'h010, 32'h01);
        le <= 1'b0;
        apb(1'b1, 12'h010, 32'h0);
        $display("alarm test done");
    endtask
    task automatic t_carry;
        apb(1'b1, 12'h010, 32'h10);
        pulse(0);
        settle(1);
        check("carry irq", irq.carry, 1'b1);
        rchk(12'h010, 32'h90);
        apb(1'b1, 12'h010, 32'h10);
        settle(0);
        check("carry irq", irq.carry, 1'b0);
        pulse(1);
        pulse(2);
        settle(1);
        check("carry irq", irq.carry, 1'b0);
        rchk(12'h010, 32'h80);
        apb(1'b1, 12'h010, 32'h0);
        $display("carry test done");
    endtask
    task automatic t_period;
        for (int s = 1; s < 8; s++) begin
            apb(1'b1, 12'h014, 32'(s * 16 + 9));
            tk <= 7'(1 << (s - 1));
            @(posedge clk);
            tk <= 7'h00;
            settle(1);
            check("periodic irq", irq.periodic, 1'b1);
            apb(1'b1, 12'h014, 32'(s * 16 + 9));
            settle(0);
            check("periodic irq", irq.periodic, 1'b0);
        end
        apb(1'b1, 12'h014, 32'h09);
        tk <= 7'h7F;
        @(posedge clk);
        tk <= 7'h00;
        rchk(12'h014, 32'h09);
        apb(1'b1, 12'h014, 32'h10);
        settle(0);
        check("oscillator", run.oscillator_enable, 1'b0);
        pulse(2);
        rchk(12'h014, 32'h00);
        apb(1'b1, 12'h014, 32'h09);
        settle(0);
        check("count start", run.count_start, 1'b1);
        $display("periodic test done");
    endtask
    task automatic t_pulses;
        apb(1'b1, 12'h014, 32'h0B);
        settle(2);
        check("divider pulses", n_div, 1);
        rchk(12'h014, 32'h09);
        apb(1'b1, 12'h014, 32'h0D);
        settle(2);
        check("adjust pulses", n_adj, 1);
        rchk(12'h014, 32'h09);
        apb(1'b0, 12'h020, 32'h0);
        check("slave error", re, 1'b1);
        $display("pulse test done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_regs;
        t_alarm;
        t_carry;
        t_period;
        t_pulses;
        conclude;
    end
    // Watchdog
    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        conclude;
    end
endmodule // rac_alarm_ctrl_tb_top
`default_nettype wire
